// File: logic/clsp_pkg.sv
// Package for the charger learn, soft-start and switching-cycle control.
// Assumes a 100 MHz system clock; all clock-cycle counts below derive from that rate.
package clsp_pkg;

  // Clock and switching timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int PWM_HZ        = 300_000;
  localparam int PERIOD_CYC    = CLK_HZ / PWM_HZ;               // 333
  localparam int DEAD_NS       = 30;
  localparam int DEAD_CYC      = (DEAD_NS * (CLK_HZ / 1_000_000) + 999)
                                 / 1000;                        // Round up
  localparam int PULSE_NS      = 80;
  localparam int PULSE_CYC     = (PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int SEL_DEAD_US   = 10;
  localparam int SEL_DEAD_CYC  = SEL_DEAD_US * (CLK_HZ / 1_000_000);
  localparam int STEP_US       = 1000;
  localparam int STEP_CYC      = STEP_US * (CLK_HZ / 1_000_000);
  localparam int SS_STEPS      = 8;
  localparam int BST_LOW_LIMIT = 3;

  // Widths
  localparam int DUTY_W = 9;
  localparam int CUR_W  = 16;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_DUTY   = 4'h4;
  localparam logic [3:0] REG_ICHG   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // Field positions and reset values
  localparam int CTRL_CHG_EN_BIT = 0;
  localparam int ST_ADAPTER_BIT  = 0;
  localparam int ST_BATTERY_BIT  = 1;
  localparam int ST_LEARN_BIT    = 2;
  localparam int ST_SYNC_BIT     = 3;
  localparam int ST_CHARGE_BIT   = 4;
  localparam int ST_SS_DONE_BIT  = 5;
  localparam int ST_REFRESH_BIT  = 6;
  localparam logic             CTRL_RESET = 1'b0;
  localparam logic [DUTY_W-1:0] DUTY_RESET = 9'h000;
  localparam logic [CUR_W-1:0]  ICHG_RESET = 16'h0000;

  // Power selector states, one-hot
  typedef enum logic [2:0] {
    SEL_BAT = 3'b001,
    SEL_GAP = 3'b010,
    SEL_AC  = 3'b100
  } clsp_sel_t;

endpackage : clsp_pkg

// File: logic/clsp_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are quasi-static levels; no pulse stretching.
`timescale 1ns/10ps
module clsp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : clsp_sync

// File: logic/clsp_ctrl.sv
// Charger control: power selector with learn override, soft-start of the
// charge-current target, and the buck gate sequencer with an Avalon slave.
// Assumes comparator flags arrive asynchronously from analog circuitry and
// the bus master follows Avalon-MM waitrequest signalling on clk.
//
// Operation
// - Learn low: selector follows adapter presence
// - Learn high with adapter: battery feeds system
// - Learn high disables charging
// - Learn exits to adapter on low battery
// - Enable ramps current target in eight steps
// - Each step held one millisecond
// - Fixed switching period from 300 kHz
// - Duty zero to full on accepted
// - Bootstrap low over three cycles forces refresh
// - Resume full on, refresh whenever low again
// - Below threshold non-synchronous, above release synchronous
// - Synchronous: complementary gates, 30 ns dead time
// - Non-synchronous: 80 ns low-side pulse only
// - Zero duty keeps high side off
// - Compare every cycle with hysteresis band
// - Synchronous threshold fixed, not programmable
// - Battery recovery during learn reconnects battery
// - Selector swap holds both off 10 us
`timescale 1ns/10ps
module clsp_ctrl
  import clsp_pkg::*;
#(
  parameter int STEP_CYCLES = clsp_pkg::STEP_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic [3:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        adapter_detected,
  input  wire logic                        learn_request,
  input  wire logic                        battery_low_threshold,
  input  wire logic                        bootstrap_supply_low,
  input  wire logic                        charge_sense_below_sync,
  input  wire logic                        charge_sense_above_release,
  input  wire logic                        charge_conditions_ok,
  output logic                             adapter_switch_drive,
  output logic                             battery_switch_drive,
  output logic                             high_side_gate_drive,
  output logic                             low_side_gate_drive,
  output logic [clsp_pkg::CUR_W-1:0]       charge_current_target,
  output logic                             charging_enabled
);
  import clsp_pkg::*;

  // Refuse settings the counters cannot serve
  if (STEP_CYCLES < 1 || STEP_CYCLES > 1_000_000) begin : g_chk
    $error("STEP_CYCLES out of range");
  end

  // Synchronised pin inputs
  logic [6:0] pins_s;
  logic       adapter_s;
  logic       learn_s;
  logic       bat_low_s;
  logic       bst_low_s;
  logic       below_s;
  logic       above_s;
  logic       cond_s;

  clsp_sync #(.W(7)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({adapter_detected, learn_request, battery_low_threshold,
                bootstrap_supply_low, charge_sense_below_sync,
                charge_sense_above_release, charge_conditions_ok}),
    .sync_out (pins_s)
  );

  assign {adapter_s, learn_s, bat_low_s, bst_low_s, below_s, above_s,
          cond_s} = pins_s;

  // ---------------- Register file ----------------
  logic                sw_chg_en;
  logic [DUTY_W-1:0]   duty_reg;
  logic [CUR_W-1:0]    ichg_reg;
  logic [31:0]         status_word;
  logic [31:0]         next_readdata;
  logic                bus_req;
  logic                bus_done;
  logic                wr_ctrl;
  logic                wr_duty;
  logic                wr_ichg;

  // Decode; an access completes on the cycle waitrequest is low
  assign bus_req  = avs_read | avs_write;
  assign bus_done = bus_req & ~avs_waitrequest;
  assign wr_ctrl  = bus_done & avs_write & (avs_address == REG_CTRL);
  assign wr_duty  = bus_done & avs_write & (avs_address == REG_DUTY);
  assign wr_ichg  = bus_done & avs_write & (avs_address == REG_ICHG);

  // Read mux; unmapped offsets read zero
  assign next_readdata =
      (avs_address == REG_CTRL)   ? {31'h0, sw_chg_en} :
      (avs_address == REG_DUTY)   ? {23'h0, duty_reg} :
      (avs_address == REG_ICHG)   ? {16'h0, ichg_reg} :
      (avs_address == REG_STATUS) ? status_word : 32'h0;

  // One wait state per access, then waitrequest drops for one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req & avs_waitrequest)
        avs_readdata <= next_readdata;
    end
  end

  // Software settings
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_chg_en <= CTRL_RESET;
      duty_reg  <= DUTY_RESET;
      ichg_reg  <= ICHG_RESET;
    end else begin
      if (wr_ctrl) sw_chg_en <= avs_writedata[CTRL_CHG_EN_BIT];
      if (wr_duty) duty_reg  <= avs_writedata[DUTY_W-1:0];
      if (wr_ichg) ichg_reg  <= avs_writedata[CUR_W-1:0];
    end
  end

  // ---------------- Power selector ----------------
  clsp_sel_t  sel_state;
  clsp_sel_t  next_sel;
  logic [9:0] gap_cnt;
  logic       want_ac;
  logic       gap_done;

  // Learn forces battery unless it is depleted; recovery swaps back
  assign want_ac  = adapter_s & (~learn_s | bat_low_s);
  assign gap_done = (gap_cnt == 10'(SEL_DEAD_CYC - 1));

  // Break-before-make: any swap passes through the all-off gap
  always_comb begin
    next_sel = sel_state;
    unique case (sel_state)
      SEL_BAT: if (want_ac)  next_sel = SEL_GAP;
      SEL_AC:  if (!want_ac) next_sel = SEL_GAP;
      SEL_GAP: if (gap_done) next_sel = want_ac ? SEL_AC : SEL_BAT;
      default: next_sel = SEL_GAP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_state            <= SEL_BAT;
      gap_cnt              <= 10'h000;
      adapter_switch_drive <= 1'b0;
      battery_switch_drive <= 1'b1;
    end else begin
      sel_state            <= next_sel;
      gap_cnt              <= (next_sel == SEL_GAP && sel_state == SEL_GAP)
                              ? gap_cnt + 10'h001 : 10'h000;
      adapter_switch_drive <= (next_sel == SEL_AC);
      battery_switch_drive <= (next_sel == SEL_BAT);
    end
  end

  // ---------------- Charge enable and soft-start ----------------
  logic        chg_en;
  logic        chg_en_q;
  logic [3:0]  ss_step;
  logic [19:0] ss_tick;
  logic [19:0] ss_prod;
  logic        step_end;

  assign chg_en   = cond_s & sw_chg_en & ~learn_s;
  assign step_end = (ss_tick == 20'(STEP_CYCLES - 1));
  assign ss_prod  = 20'(ichg_reg) * 20'(ss_step);

  // Restart the ramp on each enable rising edge
  always_ff @(posedge clk) begin
    if (srst) begin
      chg_en_q              <= 1'b0;
      ss_step               <= 4'h0;
      ss_tick               <= 20'h00000;
      charge_current_target <= 16'h0000;
      charging_enabled      <= 1'b0;
    end else begin
      chg_en_q         <= chg_en;
      charging_enabled <= chg_en;
      if (!chg_en || !chg_en_q) begin
        ss_step <= 4'h0;
        ss_tick <= 20'h00000;
      end else if (ss_step != 4'(SS_STEPS)) begin
        ss_tick <= step_end ? 20'h00000 : ss_tick + 20'h00001;
        if (step_end) ss_step <= ss_step + 4'h1;
      end
      // Target equals programmed current times step over eight
      charge_current_target <= chg_en ? ss_prod[CUR_W+2:3] : 16'h0000;
    end
  end

  // ---------------- Switching-cycle sequencer ----------------
  logic [8:0]        cyc_cnt;
  logic              cyc_end;
  logic [DUTY_W-1:0] duty_q;
  logic [DUTY_W-1:0] duty_clamped;
  logic              sync_mode;
  logic [1:0]        bst_cnt;
  logic              refresh;
  logic [1:0]        dead_cnt;
  logic [3:0]        ls_cnt;
  logic              dead_ok;
  logic              want_hs;
  logic              want_ls;
  logic              ls_pulse_left;
  logic              next_hs;
  logic              next_ls;

  assign cyc_end      = (cyc_cnt == 9'(PERIOD_CYC - 1));
  assign duty_clamped = (duty_reg > DUTY_W'(PERIOD_CYC))
                        ? DUTY_W'(PERIOD_CYC) : duty_reg;
  assign dead_ok       = (dead_cnt == 2'(DEAD_CYC));
  assign ls_pulse_left = (ls_cnt < 4'(PULSE_CYC));

  // High side conducts for the duty window; full duty means whole period
  assign want_hs = chg_en & ~refresh & (duty_q != '0)
                   & ({1'b0, cyc_cnt} < {1'b0, duty_q});

  // Low side: complement, short pulse, or refresh pulse
  assign want_ls = ~chg_en | (duty_q == '0) ? 1'b0 :
                   refresh   ? ls_pulse_left :
                   sync_mode ? ~want_hs :
                               ~want_hs & ls_pulse_left;

  // Break-before-make: a gate turns on only after the dead interval
  always_comb begin
    next_hs = 1'b0;
    next_ls = 1'b0;
    if (want_hs)
      next_hs = high_side_gate_drive | (~low_side_gate_drive & dead_ok);
    if (want_ls && !want_hs)
      next_ls = low_side_gate_drive | (~high_side_gate_drive & dead_ok);
  end

  // Cycle counter and per-period decisions
  always_ff @(posedge clk) begin
    if (srst) begin
      cyc_cnt   <= 9'h000;
      duty_q    <= DUTY_RESET;
      sync_mode <= 1'b0;
      bst_cnt   <= 2'h0;
      refresh   <= 1'b0;
    end else begin
      cyc_cnt <= cyc_end ? 9'h000 : cyc_cnt + 9'h001;
      if (cyc_end) begin
        duty_q <= duty_clamped;
        // Fixed-threshold comparator with hysteresis, once per period
        if (below_s)
          sync_mode <= 1'b0;
        else if (above_s)
          sync_mode <= 1'b1;
        // Count consecutive bootstrap-low periods
        if (!bst_low_s) begin
          bst_cnt <= 2'h0;
          refresh <= 1'b0;
        end else if (bst_cnt == 2'(BST_LOW_LIMIT)) begin
          bst_cnt <= 2'h0;
          refresh <= 1'b1;
        end else begin
          bst_cnt <= bst_cnt + 2'h1;
          refresh <= 1'b0;
        end
      end
    end
  end

  // Gate flops, dead-time and low-side pulse counters
  always_ff @(posedge clk) begin
    if (srst) begin
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive  <= 1'b0;
      dead_cnt             <= 2'h0;
      ls_cnt               <= 4'h0;
    end else begin
      high_side_gate_drive <= next_hs;
      low_side_gate_drive  <= next_ls;
      // Counts cycles with both gates off, saturating
      if (next_hs || next_ls)
        dead_cnt <= 2'h0;
      else if (!dead_ok)
        dead_cnt <= dead_cnt + 2'h1;
      // Low-side on time within the period, cleared at the boundary
      if (cyc_end)
        ls_cnt <= 4'h0;
      else if (next_ls && ls_pulse_left)
        ls_cnt <= ls_cnt + 4'h1;
    end
  end

  // Status word
  always_comb begin
    status_word                 = 32'h0;
    status_word[ST_ADAPTER_BIT] = adapter_switch_drive;
    status_word[ST_BATTERY_BIT] = battery_switch_drive;
    status_word[ST_LEARN_BIT]   = learn_s;
    status_word[ST_SYNC_BIT]    = sync_mode;
    status_word[ST_CHARGE_BIT]  = charging_enabled;
    status_word[ST_SS_DONE_BIT] = (ss_step == 4'(SS_STEPS));
    status_word[ST_REFRESH_BIT] = refresh;
  end

endmodule : clsp_ctrl

// File: bench/clsp_fet_model.sv
// Power stage model: bootstrap supply of the high-side gate driver.
// Assumes the supply leaks low only while the high-side gate is on.
`timescale 1ns/10ps
module clsp_fet_model #(
  parameter int LEAK_CYC = 1000
) (
  input  wire logic clk,
  input  wire logic high_side_gate_drive,
  input  wire logic low_side_gate_drive,
  output logic      bootstrap_supply_low
);
  int since_chg = 0;

  // Low-side conduction pulls the switch node down and recharges the cap
  always_ff @(posedge clk) begin
    if (low_side_gate_drive)
      since_chg <= 0;
    else if (high_side_gate_drive && since_chg < LEAK_CYC)
      since_chg <= since_chg + 1;
  end
  assign bootstrap_supply_low = (since_chg >= LEAK_CYC);
endmodule : clsp_fet_model

// File: bench/clsp_ctrl_properties.sv
// Checker for the charger control block: gates, selector and bus.
// Bound to every clsp_ctrl instance; sees its top-level ports only.
`timescale 1ns/10ps
module clsp_ctrl_properties (
  input wire logic                       clk,
  input wire logic                       srst,
  input wire logic                       avs_waitrequest,
  input wire logic                       adapter_detected,
  input wire logic                       learn_request,
  input wire logic                       battery_low_threshold,
  input wire logic                       adapter_switch_drive,
  input wire logic                       battery_switch_drive,
  input wire logic                       high_side_gate_drive,
  input wire logic                       low_side_gate_drive,
  input wire logic [clsp_pkg::CUR_W-1:0] charge_current_target,
  input wire logic                       charging_enabled
);
  wire logic hs = high_side_gate_drive;
  wire logic ls = low_side_gate_drive;
  wire logic ad = adapter_switch_drive;
  wire logic bd = battery_switch_drive;
  int        gap_cnt;
  int        low_run;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Both-off selector time and low-gate run length, measured in cycles
  always_ff @(posedge clk) begin
    gap_cnt <= (srst || ad || bd) ? 0 : gap_cnt + 1;
    low_run <= (!srst && ls) ? low_run + 1 : 0;
  end

  chk_no_overlap: assert property (!(hs && ls))
    else $error("both gates on");
  chk_hs_dead: assert property ($rose(hs) |->
    !$past(ls) && !$past(ls, 2) && !$past(ls, 3))
    else $error("high gate dead time short");
  chk_sel_break: assert property (!(ad && bd))
    else $error("both selector switches on");
  chk_sel_gap: assert property ($rose(ad) || $rose(bd) |->
    gap_cnt >= 1000 && gap_cnt <= 1002)
    else $error("selector gap wrong");
  // A charge disable may legally cut a pulse short
  chk_pulse_min: assert property (
    $fell(ls) && charging_enabled |-> low_run >= 8)
    else $error("low gate pulse short");
  chk_default_sel: assert property (
    (!learn_request && adapter_detected)[*5] |-> !bd)
    else $error("battery on with adapter");
  chk_learn_batt: assert property (
    (learn_request && adapter_detected && !battery_low_threshold)[*5]
    |-> !ad) else $error("adapter on during learn");
  chk_learn_nochg: assert property (
    learn_request[*5] |-> !charging_enabled)
    else $error("charging during learn");
  chk_target_off: assert property (
    !charging_enabled[*3] |-> charge_current_target == '0)
    else $error("target not zero while off");
  chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");

  cover property ($rose(ad));
  cover property ($fell(ls) && low_run == 8);
  cover property (learn_request && bd && adapter_detected);
endmodule : clsp_ctrl_properties

bind clsp_ctrl clsp_ctrl_properties clsp_ctrl_properties_i (
  .clk, .srst, .avs_waitrequest, .adapter_detected, .learn_request,
  .battery_low_threshold, .adapter_switch_drive, .battery_switch_drive,
  .high_side_gate_drive, .low_side_gate_drive, .charge_current_target,
  .charging_enabled);

// File: bench/clsp_ctrl_tb.sv
// Testbench for clsp_ctrl: bus map, selector, soft-start and gate timing.
// Assumes one wait state per access and two edges of input sync.
`timescale 1ns/10ps
module clsp_ctrl_tb;
  import clsp_pkg::*;
  localparam int STEP = 20;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [3:0]        avs_address = 4'h0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h00000000;
  logic [31:0]       avs_readdata, rd;
  logic              avs_waitrequest, bootstrap_supply_low;
  logic              adapter_detected = 1'b0;
  logic              learn_request = 1'b0;
  logic              battery_low_threshold = 1'b0;
  logic              below = 1'b1;
  logic              above = 1'b0;
  logic              cond_ok = 1'b1;
  logic              ad, bd, hs, ls, ce;
  logic [CUR_W-1:0]  target, prev;
  int                n_fail = 0;
  int                checks_done = 0;
  int                w, g;

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  clsp_ctrl #(.STEP_CYCLES(STEP)) clsp_ctrl_i (
    .clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .adapter_detected, .learn_request,
    .battery_low_threshold, .bootstrap_supply_low,
    .charge_sense_below_sync(below), .charge_sense_above_release(above),
    .charge_conditions_ok(cond_ok), .adapter_switch_drive(ad),
    .battery_switch_drive(bd), .high_side_gate_drive(hs),
    .low_side_gate_drive(ls), .charge_current_target(target),
    .charging_enabled(ce));

  clsp_fet_model clsp_fet_model_i (.clk, .high_side_gate_drive(hs),
    .low_side_gate_drive(ls), .bootstrap_supply_low);

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Request held until waitrequest is sampled low; one idle edge after
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    // Only the watchdog ends a wait that never completes
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  function automatic logic gate(input logic low);
    return low ? ls : hs;
  endfunction : gate

  // Length of the next on run of a gate and of the off run after it
  task automatic meas(input logic low, output int on, output int off);
    int k;
    // Skip a run already in progress so that only whole runs count
    for (k = 0; gate(low) !== 1'b0 && k < 4000; k++) @(posedge clk);
    for (k = 0; gate(low) !== 1'b1 && k < 4000; k++) @(posedge clk);
    for (on = 0; gate(low) === 1'b1 && on < 4000; on++) @(posedge clk);
    for (off = 0; gate(low) !== 1'b1 && off < 4000; off++) @(posedge clk);
  endtask : meas

  // Selector: both off shortly after a change, then the new switch on
  task automatic selchk(input logic [1:0] exp);
    cyc(20);
    cmp({ad, bd}, 2'b00);
    cyc(1000);
    cmp({ad, bd}, exp);
  endtask : selchk

  task automatic ramp();
    for (int k = 1; k <= SS_STEPS; k++) begin
      prev = target;
      for (w = 0; target === prev && w < 200; w++) @(posedge clk);
      cmp(target, 32'(k) * 32'h00000100);
      if (k > 1)
        cmp(w, STEP);
    end
  endtask : ramp

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard, far beyond the expected run of about 19000 cycles
  initial begin
    cyc(80000);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    cyc(2);
    srst <= 1'b0;
    cyc(1);
    bus(0, REG_STATUS, 0);
    cmp(rd & 32'h0000005f, 32'h00000002);
    bus(1, 4'h2, 32'hffffffff);
    bus(0, 4'h2, 0);
    cmp(rd, 32'h00000000);
    bus(0, REG_DUTY, 0);
    cmp(rd, 32'(DUTY_RESET));
    $display("register map test done");
    adapter_detected <= 1'b1;
    selchk(2'b10);
    $display("selector test done");
    bus(1, REG_DUTY, 32'h00000064);
    bus(1, REG_ICHG, 32'h00000800);
    bus(1, REG_CTRL, 32'h00000001);
    ramp();
    $display("soft-start test done");
    meas(0, w, g);
    cmp(w, 32'h00000064);
    cmp(w + g, PERIOD_CYC);
    meas(1, w, g);
    cmp(w, PULSE_CYC);
    below <= 1'b0;
    above <= 1'b1;
    cyc(2 * PERIOD_CYC);
    meas(1, w, g);
    // Leading dead time comes out of the low-side window
    cmp(w, PERIOD_CYC - 100 - DEAD_CYC);
    above <= 1'b0;
    cyc(2 * PERIOD_CYC);
    bus(0, REG_STATUS, 0);
    cmp(rd[ST_SYNC_BIT], 1'b1);
    below <= 1'b1;
    cyc(2 * PERIOD_CYC);
    bus(0, REG_STATUS, 0);
    cmp(rd[ST_SYNC_BIT], 1'b0);
    $display("mode test done");
    bus(1, REG_DUTY, 32'h0000014d);
    meas(1, w, g);
    cmp(w, PULSE_CYC);
    cmp(g > PERIOD_CYC, 1'b1);
    meas(0, w, g);
    cmp(w > 3 * PERIOD_CYC, 1'b1);
    $display("refresh test done");
    bus(1, REG_DUTY, 32'h00000000);
    cyc(2 * PERIOD_CYC);
    for (g = 0, w = 0; w < 700; w++) begin
      @(posedge clk);
      g += (hs === 1'b1);
    end
    cmp(g, 0);
    $display("zero duty test done");
    bus(1, REG_DUTY, 32'h00000064);
    learn_request <= 1'b1;
    cyc(10);
    cmp(ce, 1'b0);
    selchk(2'b01);
    battery_low_threshold <= 1'b1;
    selchk(2'b10);
    battery_low_threshold <= 1'b0;
    selchk(2'b01);
    learn_request <= 1'b0;
    ramp();
    selchk(2'b10);
    $display("learn test done");
    tally_and_finish();
  end
endmodule : clsp_ctrl_tb
